/* bench/aspc_term.sv */
// serial terminal model: sends frames and decodes the port output
`timescale 1ns/10ps

module aspc_term #(
    parameter int BIT = 32
) (
    // clock
    input wire logic sys_clk,
    // serial line
    input wire logic txLine,
    output logic     rxLine
);
    initial rxLine = 1'b1;

    // lsb first, one bit time each, then the given idle level
    task automatic drive(input logic [11:0] f, input int n, input logic idle);
        @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            rxLine <= f[i];
            repeat (BIT) @(posedge sys_clk);
        end
        rxLine <= idle;
    endtask

    // waits for a start bit, then samples mid-bit
    task automatic grab(output logic [11:0] f, input int n, output bit ok);
        int t;
        f = 12'hfff;
        t = 0;
        while (txLine !== 1'b0 && t < 400) begin
            @(posedge sys_clk);
            t++;
        end
        ok = (t < 400);
        repeat (BIT / 2) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            f[i] = txLine;
            repeat (BIT) @(posedge sys_clk);
        end
    endtask
endmodule

/* bench/aspc_uart_chk.sv */
// port-level checks of the serial port control block
`timescale 1ns/10ps
`include "aspc_params.svh"

module aspc_uart_chk (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       clkEn,
    // register port
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdData,
    // line and flags
    input wire logic       serialOut,
    input wire logic       rxIrq,
    input wire logic       txIrq,
    input wire logic       rxFull,
    input wire logic       txEmpty
);
    logic [4:0] icEn_ff;
    logic [7:0] lineFmt_ff;

    // shadow copies of the writable control bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            icEn_ff    <= `ASPC_RST_INTCTL;
            lineFmt_ff <= `ASPC_RST_LINE;
        end else if (regWr && clkEn) begin
            if (regAddr == `ASPC_OFS_INTCTL) icEn_ff <= regWrData[4:0];
            if (regAddr == `ASPC_OFS_LINE) lineFmt_ff <= regWrData;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_acc(logic s, logic [1:0] a);
        s && clkEn && regAddr == a;
    endsequence

    a_rdata_idle: assert property ($past(clkEn) && !$past(regRd)
        |-> regRdData == 8'h00)
        else $error("read data not zero outside read");
    a_intctl_read: assert property (s_acc(regRd, `ASPC_OFS_INTCTL)
        |=> regRdData[6:0] == {2'b00, $past(icEn_ff)})
        else $error("interrupt control readback wrong");
    a_line_read: assert property (s_acc(regRd, `ASPC_OFS_LINE)
        |=> regRdData == $past(lineFmt_ff))
        else $error("line format readback wrong");
    a_txempty_clear: assert property (s_acc(regWr, `ASPC_OFS_DATA)
        |=> !txEmpty)
        else $error("buffer write did not clear empty");
    a_rxfull_clear: assert property (s_acc(regRd, `ASPC_OFS_DATA)
        |=> !rxFull)
        else $error("buffer read did not clear full");
    a_tx_irq_mask: assert property (!icEn_ff[1] && !$past(icEn_ff[1])
        |-> !txIrq)
        else $error("transmit interrupt while disabled");
    a_tx_irq_on: assert property ((icEn_ff[1] && txEmpty) [*2]
        |-> txIrq)
        else $error("transmit interrupt missing");
    a_rx_irq_full: assert property ((icEn_ff[0] && rxFull) [*2]
        |-> rxIrq)
        else $error("receive interrupt missing");
    a_rx_irq_mask: assert property (!(icEn_ff[0] || icEn_ff[2]) [*2]
        |-> !rxIrq)
        else $error("receive interrupt while disabled");
    a_break_low: assert property (lineFmt_ff[6] [*4]
        |-> !serialOut)
        else $error("line not low during break");
endmodule

bind aspc_uart_top aspc_uart_chk chk_u (.sys_clk, .rst_n, .clkEn, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .serialOut, .rxIrq, .txIrq,
    .rxFull, .txEmpty);

/* bench/test_aspc_uart_top.sv */
// self-checking bench of the serial port control block
`timescale 1ns/10ps
`include "aspc_params.svh"

module test_aspc_uart_top;
    // two clocks per tick, sixteen ticks per bit
    localparam int BIT = 32;
    logic        sys_clk;
    logic        rst_n;
    logic        sampleTick = 1'b0;
    logic [1:0]  regAddr;
    logic [7:0]  regWrData;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regRdData;
    logic        dmaRxRd;
    logic        serialIn;
    logic        serialOut;
    logic        rxIrq;
    logic        txIrq;
    logic        rxFull;
    logic        txEmpty;
    logic [11:0] frm;
    logic [11:0] got;
    int          nBits;
    int          mismatches;
    int          checks;
    bit          ok;
    logic [7:0]  fmts [6] = '{8'h03, 8'h00, 8'h1a, 8'h09, 8'ha8, 8'h07};

    aspc_uart_top dut_u (.sys_clk, .rst_n, .clkEn(1'b1), .sampleTick,
        .regAddr, .regWrData, .regWr, .regRd, .regRdData, .dmaRxRd,
        .serialIn, .serialOut, .rxIrq, .txIrq, .rxFull, .txEmpty);
    aspc_term #(.BIT(BIT)) term_u (.sys_clk(sys_clk), .txLine(serialOut),
        .rxLine(serialIn));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) sampleTick <= ~sampleTick;

    task automatic check(input string name, input logic [11:0] seen,
                         input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e,
                      input string name);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        check(name, regRdData, e);
    endtask

    // expected frame bits, lsb sent first; bad flips the parity bit
    function automatic void mkFrame(input logic [7:0] d,
                                    input logic [7:0] lf, input logic bad);
        logic p;
        p = ~lf[4];
        frm = 12'hfff;
        frm[0] = 1'b0;
        nBits = 6 + lf[1:0];
        for (int i = 0; i < nBits - 1; i++) begin
            frm[1 + i] = d[i];
            p ^= d[i];
        end
        if (lf[3]) begin
            frm[nBits] = (lf[5] ? lf[7] : p) ^ bad;
            nBits++;
        end
        nBits += 1 + lf[2];
    endfunction

    task automatic send(input logic [7:0] d, input logic [7:0] lf,
                        input logic badPar, input logic badStop);
        mkFrame(d, lf, badPar);
        if (badStop) frm[nBits - 1] = 1'b0;
        term_u.drive(frm, nBits, 1'b1);
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic finish_test();
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        regAddr = 2'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        dmaRxRd = 1'b0;
        mismatches = 0;
        checks = 0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`ASPC_OFS_INTCTL, 8'h00, "intctl reset");
        rd(`ASPC_OFS_LINE, 8'h03, "line reset");
        rd(`ASPC_OFS_STATUS, 8'h20, "status reset");
        wr(`ASPC_OFS_INTCTL, 8'hff);
        rd(`ASPC_OFS_INTCTL, 8'h1f, "intctl bits");
        wr(`ASPC_OFS_STATUS, 8'h00);
        rd(`ASPC_OFS_STATUS, 8'h20, "status write");
        check("txIrq on", txIrq, 1'b1);
        wr(`ASPC_OFS_INTCTL, 8'h00);
        repeat (3) @(posedge sys_clk);
        check("txIrq off", txIrq, 1'b0);
        wr(`ASPC_OFS_LINE, 8'h43);
        repeat (4) @(posedge sys_clk);
        check("break line", serialOut, 1'b0);
        wr(`ASPC_OFS_LINE, 8'h03);
        repeat (4) @(posedge sys_clk);
        check("idle line", serialOut, 1'b1);
        foreach (fmts[k]) begin
            wr(`ASPC_OFS_LINE, fmts[k]);
            wr(`ASPC_OFS_DATA, 8'ha5);
            repeat (4) @(posedge sys_clk);
            rd(`ASPC_OFS_STATUS, 8'h20, "status taken");
            mkFrame(8'ha5, fmts[k], 1'b0);
            term_u.grab(got, nBits, ok);
            check("tx start", ok, 1'b1);
            if (!ok) finish_test();
            check("tx frame", got, frm);
            repeat (BIT) @(posedge sys_clk);
            rd(`ASPC_OFS_STATUS, 8'h60, "underrun");
        end
        wr(`ASPC_OFS_LINE, 8'h03);
        wr(`ASPC_OFS_INTCTL, 8'h01);
        send(8'h3c, 8'h03, 1'b0, 1'b0);
        check("rxIrq full", rxIrq, 1'b1);
        rd(`ASPC_OFS_STATUS, 8'h61, "status full");
        rd(`ASPC_OFS_DATA, 8'h3c, "rx data");
        repeat (2) @(posedge sys_clk);
        check("rxIrq clear", rxIrq, 1'b0);
        send(8'h11, 8'h03, 1'b0, 1'b0);
        send(8'h22, 8'h03, 1'b0, 1'b0);
        rd(`ASPC_OFS_INTCTL, 8'h81, "status flag");
        wr(`ASPC_OFS_INTCTL, 8'h04);
        repeat (2) @(posedge sys_clk);
        check("rxIrq status", rxIrq, 1'b1);
        rd(`ASPC_OFS_STATUS, 8'h63, "overrun");
        repeat (2) @(posedge sys_clk);
        check("rxIrq flag clear", rxIrq, 1'b0);
        rd(`ASPC_OFS_DATA, 8'h22, "overwrite");
        rd(`ASPC_OFS_STATUS, 8'h60, "overrun clear");
        send(8'h55, 8'h03, 1'b0, 1'b1);
        rd(`ASPC_OFS_STATUS, 8'h69, "framing");
        @(posedge sys_clk);
        dmaRxRd <= 1'b1;
        @(posedge sys_clk);
        dmaRxRd <= 1'b0;
        rd(`ASPC_OFS_STATUS, 8'h68, "dma clear");
        send(8'h0f, 8'h03, 1'b0, 1'b0);
        rd(`ASPC_OFS_STATUS, 8'h61, "framing clear");
        rd(`ASPC_OFS_DATA, 8'h0f, "rx data 2");
        term_u.drive(12'h000, 10, 1'b0);
        repeat (BIT) @(posedge sys_clk);
        rd(`ASPC_OFS_STATUS, 8'h79, "break");
        term_u.drive(12'h001, 1, 1'b1);
        rd(`ASPC_OFS_STATUS, 8'h69, "break clear");
        rd(`ASPC_OFS_DATA, 8'h00, "break data");
        wr(`ASPC_OFS_LINE, 8'h1b);
        send(8'h01, 8'h1b, 1'b1, 1'b0);
        rd(`ASPC_OFS_STATUS, 8'h65, "parity error");
        rd(`ASPC_OFS_DATA, 8'h01, "rx data 3");
        send(8'h01, 8'h1b, 1'b0, 1'b0);
        rd(`ASPC_OFS_STATUS, 8'he1, "parity clear");
        wr(`ASPC_OFS_LINE, 8'h00);
        send(8'hff, 8'h00, 1'b0, 1'b0);
        rd(`ASPC_OFS_DATA, 8'h1f, "short word");
        finish_test();
    end
endmodule

/* verilog/aspc_params.svh */
// register offsets, field positions, reset values and timing counts
`ifndef ASPC_PARAMS_SVH
`define ASPC_PARAMS_SVH

// register offsets (byte-wide; the data offset reads the receive buffer and writes the transmit holding buffer)
`define ASPC_OFS_DATA    2'h0
`define ASPC_OFS_INTCTL  2'h1
`define ASPC_OFS_LINE    2'h2
`define ASPC_OFS_STATUS  2'h3

// interrupt control fields
`define ASPC_IC_RXFULL_EN  0
`define ASPC_IC_TXEMPTY_EN 1
`define ASPC_IC_STATUS_EN  2
`define ASPC_IC_STATUS_FLAG 7

// line format fields
`define ASPC_LF_LEN_LO   0
`define ASPC_LF_TWOSTOP  2
`define ASPC_LF_PAREN    3
`define ASPC_LF_EVEN     4
`define ASPC_LF_STUFFEN  5
`define ASPC_LF_BREAK    6
`define ASPC_LF_STUFFVAL 7

// condition register fields
`define ASPC_ST_RXFULL   0
`define ASPC_ST_OVERRUN  1
`define ASPC_ST_PARERR   2
`define ASPC_ST_FRAMERR  3
`define ASPC_ST_BREAK    4
`define ASPC_ST_TXEMPTY  5
`define ASPC_ST_UNDERRUN 6
`define ASPC_ST_RXPAR    7

// reset values
`define ASPC_RST_INTCTL  5'h00
`define ASPC_RST_LINE    8'h03
`define ASPC_RST_STATUS  8'h20

// oversampling: last tick of a bit (16 ticks per bit) and last tick to mid start bit
`define ASPC_TICK_LAST   4'hf
`define ASPC_TICK_MID    4'h7

`endif

/* verilog/aspc_pkg.sv */
// types and shared helpers of the serial port control block
package aspc_pkg;

    typedef enum logic [2:0] {
        SER_IDLE,
        SER_START,
        SER_DATA,
        SER_PARITY,
        SER_STOP
    } aspc_ser_e;

    typedef struct packed {
        aspc_ser_e   state;
        logic [3:0]  tick;
        logic [2:0]  bitIdx;
        logic [7:0]  shift;
        logic        parBit;
        logic [1:0]  len;
        logic        parEn;
        logic        twoStop;
        logic        stopDone;
        logic        line;
        logic        take;
        logic        done;
    } aspc_tx_s;

    typedef struct packed {
        logic        rxS1;
        logic        rxS2;
        logic        rxPrev;
        aspc_ser_e   rxState;
        logic [3:0]  rxTick;
        logic [2:0]  rxBit;
        logic [7:0]  rxShift;
        logic        rxPar;
        logic        rxLow;
        logic [7:0]  rxBuf;
        logic [7:0]  stat;
        logic [4:0]  intCtl;
        logic        statFlag;
        logic [7:0]  lineFmt;
        logic [7:0]  txHold;
        logic [7:0]  rdData;
        logic        serialOut;
        logic        rxIrq;
        logic        txIrq;
    } aspc_top_s;

    // data bits beyond the word length are zeroed
    function automatic logic [7:0] maskWord(input logic [7:0] d,
                                            input logic [1:0] len);
        logic [7:0] m;
        m = 8'hff >> (3'd3 - {1'b0, len});
        return d & m;
    endfunction

    // parity bit to send: stuffed value, even or odd
    function automatic logic parityOf(input logic [7:0] d,
                                      input logic [1:0] len,
                                      input logic       even,
                                      input logic       stuffEn,
                                      input logic       stuffVal);
        logic p;
        p = ^maskWord(d, len);
        if (stuffEn) begin
            return stuffVal;
        end
        return even ? p : ~p;
    endfunction

endpackage

/* verilog/aspc_tx.sv */
// transmit shifter: start, data lsb first, parity, stop bits
`timescale 1ns/10ps
`include "aspc_params.svh"

module aspc_tx (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    input  wire logic       sampleTick,
    // holding buffer side
    input  wire logic       loadValid,
    input  wire logic [7:0] loadData,
    output logic            take,
    output logic            done,
    // format
    input  wire logic [7:0] lineFmt,
    // serial line
    output logic            line
);

    aspc_pkg::aspc_tx_s st_ff;
    aspc_pkg::aspc_tx_s nxt_st;
    logic               bitEnd;
    logic [2:0]         lastBit;

    assign take = st_ff.take;
    assign done = st_ff.done;
    assign line = st_ff.line;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.take = 1'b0;
        nxt_st.done = 1'b0;
        bitEnd      = sampleTick && (st_ff.tick == `ASPC_TICK_LAST);
        lastBit     = 3'd4 + {1'b0, st_ff.len};
        if (sampleTick) begin
            nxt_st.tick = st_ff.tick + 4'h1;
        end
        case (st_ff.state)
            aspc_pkg::SER_IDLE: begin
                nxt_st.line = 1'b1;
                nxt_st.tick = 4'h0;
                if (loadValid) begin
                    nxt_st.take    = 1'b1;
                    nxt_st.state   = aspc_pkg::SER_START;
                    nxt_st.line    = 1'b0;
                    nxt_st.len     = lineFmt[`ASPC_LF_LEN_LO +: 2];
                    nxt_st.parEn   = lineFmt[`ASPC_LF_PAREN];
                    nxt_st.twoStop = lineFmt[`ASPC_LF_TWOSTOP];
                    nxt_st.shift   = aspc_pkg::maskWord(loadData,
                                         lineFmt[`ASPC_LF_LEN_LO +: 2]);
                    nxt_st.parBit  = aspc_pkg::parityOf(loadData,
                                         lineFmt[`ASPC_LF_LEN_LO +: 2],
                                         lineFmt[`ASPC_LF_EVEN],
                                         lineFmt[`ASPC_LF_STUFFEN],
                                         lineFmt[`ASPC_LF_STUFFVAL]);
                end
            end
            aspc_pkg::SER_START: begin
                if (bitEnd) begin
                    nxt_st.state  = aspc_pkg::SER_DATA;
                    nxt_st.bitIdx = 3'd0;
                    nxt_st.line   = st_ff.shift[0];
                end
            end
            aspc_pkg::SER_DATA: begin
                if (bitEnd) begin
                    nxt_st.bitIdx = st_ff.bitIdx + 3'd1;
                    nxt_st.line   = st_ff.shift[st_ff.bitIdx + 3'd1];
                    if (st_ff.bitIdx == lastBit) begin
                        nxt_st.stopDone = 1'b0;
                        if (st_ff.parEn) begin
                            nxt_st.state = aspc_pkg::SER_PARITY;
                            nxt_st.line  = st_ff.parBit;
                        end else begin
                            nxt_st.state = aspc_pkg::SER_STOP;
                            nxt_st.line  = 1'b1;
                        end
                    end
                end
            end
            aspc_pkg::SER_PARITY: begin
                if (bitEnd) begin
                    nxt_st.state = aspc_pkg::SER_STOP;
                    nxt_st.line  = 1'b1;
                end
            end
            aspc_pkg::SER_STOP: begin
                nxt_st.line = 1'b1;
                if (bitEnd) begin
                    if (st_ff.twoStop && !st_ff.stopDone) begin
                        nxt_st.stopDone = 1'b1;
                    end else begin
                        nxt_st.state = aspc_pkg::SER_IDLE;
                        nxt_st.done  = 1'b1;
                    end
                end
            end
            default: begin
                nxt_st.state = aspc_pkg::SER_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff       <= '0;
            st_ff.state <= aspc_pkg::SER_IDLE;
            st_ff.line  <= 1'b1;
        end else if (clkEn) begin
            st_ff <= nxt_st;
        end
    end

endmodule

/* verilog/aspc_uart_top.sv */
// serial port registers, receiver, status flags and interrupts
//
// What this block does
// - status flag set by errors or break change
// - status flag raises receive interrupt when enabled
// - transmit interrupt while holding buffer empty
// - receive interrupt while receive buffer full
// - stuffing sends line bit 7 as parity
// - break bit forces transmit line low
// - even parity when selected, else odd
// - parity enable adds and checks parity bit
// - two stop bits when bit 2 set
// - bits 1:0 pick five to eight bits
// - full flag set on load, cleared by read
// - overrun on overwrite, cleared by buffer read
// - parity error until good parity arrives
// - framing error until valid stop arrives
// - break while low start through stop
// - transmit empty flag cleared by buffer write
// - underrun when shifter drained, line held high
// - received parity bit copied to bit 7
// - one address: read receive, write transmit
// - interrupt bits 4:0 writable, rest read-only
// - all registers eight bits wide
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "aspc_params.svh"

module aspc_uart_top (
    // clock, reset, enable
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    // 16x bit-rate tick from the baud generator
    input  wire logic       sampleTick,
    // register port
    input  wire logic [1:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    // dma read of the receive buffer
    input  wire logic       dmaRxRd,
    // serial line
    input  wire logic       serialIn,
    output logic            serialOut,
    // interrupts and buffer flags
    output logic            rxIrq,
    output logic            txIrq,
    output logic            rxFull,
    output logic            txEmpty
);

    aspc_pkg::aspc_top_s st_ff;
    aspc_pkg::aspc_top_s nxt_st;

    logic       txTake;
    logic       txDone;
    logic       txLine;
    logic       bitEnd;
    logic       rxEvt;
    logic       rxStopOk;
    logic       rxBrk;
    logic       rxExpPar;
    logic [7:0] rxWord;
    logic [2:0] rxLastBit;
    logic       dataRd;
    logic       dataWr;
    logic       bufRead;
    logic       rise31;

    assign regRdData = st_ff.rdData;
    assign serialOut = st_ff.serialOut;
    assign rxIrq     = st_ff.rxIrq;
    assign txIrq     = st_ff.txIrq;
    assign rxFull    = st_ff.stat[`ASPC_ST_RXFULL];
    assign txEmpty   = st_ff.stat[`ASPC_ST_TXEMPTY];

    ////////////////////////////////////////////////////////////////////////
    // transmitter

    aspc_tx u_tx (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clkEn      (clkEn),
        .sampleTick (sampleTick),
        .loadValid  (!st_ff.stat[`ASPC_ST_TXEMPTY]),
        .loadData   (st_ff.txHold),
        .take       (txTake),
        .done       (txDone),
        .lineFmt    (st_ff.lineFmt),
        .line       (txLine)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st    = st_ff;
        rxEvt     = 1'b0;
        rxStopOk  = 1'b0;
        rxBrk     = 1'b0;
        bitEnd    = sampleTick && (st_ff.rxTick == `ASPC_TICK_LAST);
        rxLastBit = 3'd4 + {1'b0, st_ff.lineFmt[`ASPC_LF_LEN_LO +: 2]};
        rxWord    = aspc_pkg::maskWord(st_ff.rxShift,
                        st_ff.lineFmt[`ASPC_LF_LEN_LO +: 2]);
        rxExpPar  = aspc_pkg::parityOf(rxWord,
                        st_ff.lineFmt[`ASPC_LF_LEN_LO +: 2],
                        st_ff.lineFmt[`ASPC_LF_EVEN],
                        st_ff.lineFmt[`ASPC_LF_STUFFEN],
                        st_ff.lineFmt[`ASPC_LF_STUFFVAL]);
        dataRd    = regRd && (regAddr == `ASPC_OFS_DATA);
        dataWr    = regWr && (regAddr == `ASPC_OFS_DATA);
        bufRead   = dataRd || dmaRxRd;

        // input synchroniser; only the second and third stages are looked at
        nxt_st.rxS1   = serialIn;
        nxt_st.rxS2   = st_ff.rxS1;
        nxt_st.rxPrev = st_ff.rxS2;

        // receiver
        if (sampleTick) begin
            nxt_st.rxTick = st_ff.rxTick + 4'h1;
        end
        case (st_ff.rxState)
            aspc_pkg::SER_IDLE: begin
                nxt_st.rxTick = 4'h0;
                if (st_ff.rxPrev && !st_ff.rxS2) begin
                    nxt_st.rxState = aspc_pkg::SER_START;
                    nxt_st.rxLow   = 1'b1;
                end
            end
            aspc_pkg::SER_START: begin
                // reject glitches shorter than half a bit
                if (sampleTick && (st_ff.rxTick == `ASPC_TICK_MID)) begin
                    nxt_st.rxTick = 4'h0;
                    nxt_st.rxBit  = 3'd0;
                    if (st_ff.rxS2) begin
                        nxt_st.rxState = aspc_pkg::SER_IDLE;
                    end else begin
                        nxt_st.rxState = aspc_pkg::SER_DATA;
                    end
                end
            end
            aspc_pkg::SER_DATA: begin
                if (bitEnd) begin
                    nxt_st.rxShift[st_ff.rxBit] = st_ff.rxS2;
                    nxt_st.rxLow = st_ff.rxLow & ~st_ff.rxS2;
                    nxt_st.rxBit = st_ff.rxBit + 3'd1;
                    if (st_ff.rxBit == rxLastBit) begin
                        if (st_ff.lineFmt[`ASPC_LF_PAREN]) begin
                            nxt_st.rxState = aspc_pkg::SER_PARITY;
                        end else begin
                            nxt_st.rxState = aspc_pkg::SER_STOP;
                        end
                    end
                end
            end
            aspc_pkg::SER_PARITY: begin
                if (bitEnd) begin
                    nxt_st.rxPar   = st_ff.rxS2;
                    nxt_st.rxLow   = st_ff.rxLow & ~st_ff.rxS2;
                    nxt_st.rxState = aspc_pkg::SER_STOP;
                end
            end
            aspc_pkg::SER_STOP: begin
                if (bitEnd) begin
                    rxEvt          = 1'b1;
                    rxStopOk       = st_ff.rxS2;
                    rxBrk          = st_ff.rxLow & ~st_ff.rxS2;
                    nxt_st.rxState = aspc_pkg::SER_IDLE;
                end
            end
            default: begin
                nxt_st.rxState = aspc_pkg::SER_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // receive status; a set in the same cycle beats a clear

        if (bufRead) begin
            nxt_st.stat[`ASPC_ST_RXFULL]  = 1'b0;
            nxt_st.stat[`ASPC_ST_OVERRUN] = 1'b0;
        end
        if (st_ff.rxS2) begin
            nxt_st.stat[`ASPC_ST_BREAK] = 1'b0;
        end
        if (rxEvt) begin
            nxt_st.rxBuf = rxWord;
            nxt_st.stat[`ASPC_ST_RXFULL] = 1'b1;
            if (st_ff.stat[`ASPC_ST_RXFULL]) begin
                nxt_st.stat[`ASPC_ST_OVERRUN] = 1'b1;
            end
            nxt_st.stat[`ASPC_ST_FRAMERR] = ~rxStopOk;
            if (st_ff.lineFmt[`ASPC_LF_PAREN]) begin
                nxt_st.stat[`ASPC_ST_PARERR] =
                    (st_ff.rxPar != rxExpPar);
                nxt_st.stat[`ASPC_ST_RXPAR] = st_ff.rxPar;
            end
            if (rxBrk) begin
                nxt_st.stat[`ASPC_ST_BREAK] = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // transmit status

        if (txTake) begin
            nxt_st.stat[`ASPC_ST_TXEMPTY] = 1'b1;
        end
        if (dataWr) begin
            nxt_st.txHold = regWrData;
            nxt_st.stat[`ASPC_ST_TXEMPTY]  = 1'b0;
            nxt_st.stat[`ASPC_ST_UNDERRUN] = 1'b0;
        end
        if (txDone && st_ff.stat[`ASPC_ST_TXEMPTY]) begin
            nxt_st.stat[`ASPC_ST_UNDERRUN] = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////
        // register writes and reads

        if (regWr && (regAddr == `ASPC_OFS_INTCTL)) begin
            nxt_st.intCtl = regWrData[4:0];
        end
        if (regWr && (regAddr == `ASPC_OFS_LINE)) begin
            nxt_st.lineFmt = regWrData;
        end

        nxt_st.rdData = 8'h00;
        if (regRd) begin
            case (regAddr)
                `ASPC_OFS_DATA:   nxt_st.rdData = st_ff.rxBuf;
                `ASPC_OFS_INTCTL: nxt_st.rdData =
                    {st_ff.statFlag, 2'b00, st_ff.intCtl};
                `ASPC_OFS_LINE:   nxt_st.rdData = st_ff.lineFmt;
                `ASPC_OFS_STATUS: nxt_st.rdData = st_ff.stat;
                default:          nxt_st.rdData = 8'h00;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // status interrupt flag; cleared by reading the condition register

        rise31 = |(nxt_st.stat[3:1] & ~st_ff.stat[3:1]);
        if (regRd && (regAddr == `ASPC_OFS_STATUS)) begin
            nxt_st.statFlag = 1'b0;
        end
        if (rise31 || (nxt_st.stat[`ASPC_ST_BREAK] !=
                       st_ff.stat[`ASPC_ST_BREAK])) begin
            nxt_st.statFlag = 1'b1;
        end

        // interrupt outputs from the updated flags
        nxt_st.rxIrq =
            (nxt_st.intCtl[`ASPC_IC_STATUS_EN] & nxt_st.statFlag) |
            (nxt_st.intCtl[`ASPC_IC_RXFULL_EN] &
             nxt_st.stat[`ASPC_ST_RXFULL]);
        nxt_st.txIrq = nxt_st.intCtl[`ASPC_IC_TXEMPTY_EN] &
                       nxt_st.stat[`ASPC_ST_TXEMPTY];

        // break overrides whatever the shifter drives
        nxt_st.serialOut = st_ff.lineFmt[`ASPC_LF_BREAK] ? 1'b0 : txLine;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff           <= '0;
            st_ff.rxS1      <= 1'b1;
            st_ff.rxS2      <= 1'b1;
            st_ff.rxPrev    <= 1'b1;
            st_ff.rxState   <= aspc_pkg::SER_IDLE;
            st_ff.stat      <= `ASPC_RST_STATUS;
            st_ff.intCtl    <= `ASPC_RST_INTCTL;
            st_ff.lineFmt   <= `ASPC_RST_LINE;
            st_ff.serialOut <= 1'b1;
        end else if (clkEn) begin
            st_ff <= nxt_st;
        end
    end

endmodule
